// file: design/prs_sequencer.sv
// Functional notes
// - main supply above shutdown threshold starts core soft-start, about 5 ms
// - 3.3 V and 2.5 V start after core soft-start and core above lockout
// - all three primary rails up: rails-ok rises after 150 ms
// - primary rails up also starts linear, 5 V and motor rails
// - each linear rail, 5 V and motor rail can be disabled by software
// - linear rails held off whenever 5 V rail is absent
// - supply-good only while rails-ok and main supply above lockout
// - main supply below lockout drops supply-good, regulators keep running
// - main supply below shutdown threshold turns every channel off
// - any primary rail low drops rails-ok and supply-good at once
// - thermal, charge-pump, internal-regulator or supply fault disables all channels
// - overtemperature warning at 130 C
// - immediate shutdown at 165 C
// - after thermal shutdown, restart with soft-start below hysteresis
// - external reset returns serial-port registers, except the motor-rail disable bit, to power-on states
// - fan mask exempts fans; otherwise disabled with 0% duty
// - regulator mask exempts linear rails and 5 V; otherwise enabled
// - motor config mask exempts motor config; otherwise zero
// - motor output-enable mask exempts that bit; otherwise disabled
`timescale 1ns/1ps
module prs_sequencer import prs_pkg::*; #(
    parameter int SOFT_START_CNT = SOFT_START_CYCLES,
    parameter int RAILS_OK_CNT = RAILS_OK_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire prs_cmp_t cmp_in,
    input wire logic [TEMP_W-1:0] junction_temp,
    input wire logic ext_reset_n,
    input wire prs_mask_t reset_mask,
    input wire logic wr_en,
    input wire prs_opt_t wr_opt_disable,
    input wire logic [FAN_N-1:0] wr_fan_en,
    input wire logic [FAN_N*PWM_W-1:0] wr_fan_pwm,
    input wire logic [MOTOR_CFG_W-1:0] wr_motor_cfg,
    input wire logic wr_motor_outen,
    output prs_en_t rail_en,
    output logic rails_ok_flag,
    output logic supply_good_flag,
    output logic overtemp_warn,
    output logic thermal_shutdown,
    output logic [FAN_N-1:0] fan_en,
    output logic [FAN_N*PWM_W-1:0] fan_pwm,
    output logic [MOTOR_CFG_W-1:0] motor_cfg,
    output logic motor_outen,
    output prs_opt_t opt_disable
);
    // comparators are analog and asynchronous to clock
    prs_cmp_t cmp_s1_reg, cmp_s2_reg;
    logic [TEMP_W-1:0] temp_s1_reg, temp_s2_reg;
    logic xr_s1_reg, xr_s2_reg;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cmp_s1_reg <= '0;
            cmp_s2_reg <= '0;
            temp_s1_reg <= '0;
            temp_s2_reg <= '0;
            xr_s1_reg <= 1'b1;
            xr_s2_reg <= 1'b1;
        end else if (clk_en) begin
            cmp_s1_reg <= cmp_in;
            cmp_s2_reg <= cmp_s1_reg;
            temp_s1_reg <= junction_temp;
            temp_s2_reg <= temp_s1_reg;
            xr_s1_reg <= ext_reset_n;
            xr_s2_reg <= xr_s1_reg;
        end
    end

    // thermal latch with hysteresis
    logic tsd_reg, tsd_next, warn_reg, warn_next;
    always_comb begin
        tsd_next = tsd_reg;
        if (temp_s2_reg >= TEMP_SHUT_C) begin
            tsd_next = 1'b1;
        end else if (temp_s2_reg < TEMP_HYST_C) begin
            tsd_next = 1'b0;
        end
        warn_next = temp_s2_reg >= TEMP_WARN_C;
    end

    // sequencer
    prs_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic fault, prim_ok;
    always_comb begin
        // temperature compared raw so shutdown is not delayed by the latch
        fault = !cmp_s2_reg.main_undervolt_shutdown || !cmp_s2_reg.charge_pump_voltage
            || !cmp_s2_reg.internal_reg_voltage || tsd_reg
            || (temp_s2_reg >= TEMP_SHUT_C);
        prim_ok = cmp_s2_reg.core_rail && cmp_s2_reg.rail_3v3 && cmp_s2_reg.rail_2v5;
        state_next = state_reg;
        cnt_next = cnt_reg;
        if (fault) begin
            state_next = PRS_OFF;
            cnt_next = '0;
        end else begin
            case (state_reg)
                PRS_OFF: begin
                    state_next = PRS_CORE_SS;
                    cnt_next = '0;
                end
                PRS_CORE_SS: begin
                    if (cnt_reg >= CNT_W'(SOFT_START_CNT - 1)) begin
                        if (cmp_s2_reg.core_rail) begin
                            state_next = PRS_PRIM_SS;
                            cnt_next = '0;
                        end
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
                PRS_PRIM_SS: begin
                    if (prim_ok) begin
                        state_next = PRS_DELAY;
                        cnt_next = '0;
                    end
                end
                PRS_DELAY: begin
                    if (!prim_ok) begin
                        state_next = PRS_PRIM_SS;
                        cnt_next = '0;
                    end else if (cnt_reg >= CNT_W'(RAILS_OK_CNT - 1)) begin
                        state_next = PRS_RUN;
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
                PRS_RUN: begin
                    if (!prim_ok) begin
                        state_next = PRS_PRIM_SS;
                        cnt_next = '0;
                    end
                end
                default: begin
                    state_next = PRS_OFF;
                    cnt_next = '0;
                end
            endcase
        end
    end

    // serial-port registers with masked external reset
    logic xr_act;
    logic [MOTOR_CFG_W-1:0] mcfg_reg, mcfg_next;
    logic moe_reg, moe_next;
    prs_opt_t opt_reg, opt_next;
    always_comb begin
        xr_act = !xr_s2_reg;
        mcfg_next = mcfg_reg;
        moe_next = moe_reg;
        opt_next = opt_reg;
        if (wr_en) begin
            mcfg_next = wr_motor_cfg;
            moe_next = wr_motor_outen;
            opt_next = wr_opt_disable;
        end
        // reset outranks a write in the same cycle
        if (xr_act && !reset_mask.regulator_reset_mask) begin
            opt_next.linear_rail_a = !REG_EN_POR;
            opt_next.linear_rail_b = !REG_EN_POR;
            opt_next.rail_5v = !REG_EN_POR;
        end
        if (xr_act && !reset_mask.motor_cfg_reset_mask) begin
            mcfg_next = MOTOR_CFG_POR;
        end
        if (xr_act && !reset_mask.motor_outen_reset_mask) begin
            moe_next = MOTOR_OUTEN_POR;
        end
    end

    // one register set per fan driver; all share the write strobe and the fan mask,
    // so a later per-fan mask only touches the reset condition here
    for (genvar fi = 0; fi < FAN_N; fi++) begin : g_fan
        logic fen_reg, fen_next;
        logic [PWM_W-1:0] fpwm_reg, fpwm_next;
        always_comb begin
            fen_next = fen_reg;
            fpwm_next = fpwm_reg;
            if (wr_en) begin
                fen_next = wr_fan_en[fi];
                fpwm_next = wr_fan_pwm[fi*PWM_W +: PWM_W];
            end
            // reset outranks a write in the same cycle
            if (xr_act && !reset_mask.fan_reset_mask) begin
                fen_next = FAN_EN_POR;
                fpwm_next = FAN_PWM_POR;
            end
        end
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                fen_reg <= FAN_EN_POR;
                fpwm_reg <= FAN_PWM_POR;
            end else if (clk_en) begin
                fen_reg <= fen_next;
                fpwm_reg <= fpwm_next;
            end
        end
        assign fan_en[fi] = fen_reg;
        assign fan_pwm[fi*PWM_W +: PWM_W] = fpwm_reg;
    end

    // outputs
    prs_en_t en_reg, en_next;
    logic rok_reg, rok_next, sgood_reg, sgood_next;
    always_comb begin
        en_next = '0;
        if (state_next != PRS_OFF) begin
            en_next.core_rail = 1'b1;
        end
        if (state_next inside {PRS_PRIM_SS, PRS_DELAY, PRS_RUN}) begin
            en_next.rail_3v3 = 1'b1;
            en_next.rail_2v5 = 1'b1;
        end
        if (state_next inside {PRS_DELAY, PRS_RUN}) begin
            en_next.rail_5v = !opt_next.rail_5v;
            en_next.motor_rail = !opt_next.motor_rail;
            // linears need the 5 V rail actually present
            en_next.linear_rail_a = !opt_next.linear_rail_a && cmp_s2_reg.rail_5v;
            en_next.linear_rail_b = !opt_next.linear_rail_b && cmp_s2_reg.rail_5v;
        end
        rok_next = (state_next == PRS_RUN);
        // below lockout only the flag falls, rails stay enabled
        sgood_next = rok_next && cmp_s2_reg.main_undervolt_lockout;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tsd_reg <= 1'b0;
            warn_reg <= 1'b0;
            state_reg <= PRS_OFF;
            cnt_reg <= '0;
            mcfg_reg <= MOTOR_CFG_POR;
            moe_reg <= MOTOR_OUTEN_POR;
            opt_reg <= '0;
            en_reg <= '0;
            rok_reg <= 1'b0;
            sgood_reg <= 1'b0;
        end else if (clk_en) begin
            tsd_reg <= tsd_next;
            warn_reg <= warn_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            mcfg_reg <= mcfg_next;
            moe_reg <= moe_next;
            opt_reg <= opt_next;
            en_reg <= en_next;
            rok_reg <= rok_next;
            sgood_reg <= sgood_next;
        end
    end

    assign rail_en = en_reg;
    assign rails_ok_flag = rok_reg;
    assign supply_good_flag = sgood_reg;
    assign overtemp_warn = warn_reg;
    assign thermal_shutdown = tsd_reg;
    assign motor_cfg = mcfg_reg;
    assign motor_outen = moe_reg;
    assign opt_disable = opt_reg;
endmodule // prs_sequencer

// file: design/prs_pkg.sv
package prs_pkg;
    // timebase
    localparam int CLK_HZ = 250_000_000;
    localparam int SOFT_START_MS = 5;
    localparam int RAILS_OK_DELAY_MS = 150;
    localparam int SOFT_START_CYCLES = SOFT_START_MS * (CLK_HZ / 1000);
    localparam int RAILS_OK_CYCLES = RAILS_OK_DELAY_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 26;
    // thermal thresholds, degrees C
    localparam int TEMP_W = 8;
    localparam logic [TEMP_W-1:0] TEMP_WARN_C = 8'd130;
    localparam logic [TEMP_W-1:0] TEMP_SHUT_C = 8'd165;
    localparam logic [TEMP_W-1:0] TEMP_HYST_C = 8'd150;
    // serial-port register widths and power-on values
    localparam int FAN_N = 3;
    localparam int PWM_W = 8;
    localparam int MOTOR_CFG_W = 16;
    localparam logic [PWM_W-1:0] FAN_PWM_POR = 8'h00;
    localparam logic FAN_EN_POR = 1'b0;
    localparam logic REG_EN_POR = 1'b1;
    localparam logic [MOTOR_CFG_W-1:0] MOTOR_CFG_POR = 16'h0000;
    localparam logic MOTOR_OUTEN_POR = 1'b0;

    typedef enum logic [4:0] {
        PRS_OFF = 5'b00001,
        PRS_CORE_SS = 5'b00010,
        PRS_PRIM_SS = 5'b00100,
        PRS_DELAY = 5'b01000,
        PRS_RUN = 5'b10000
    } prs_state_t;

    // raw comparator results
    typedef struct packed {
        logic main_undervolt_shutdown;
        logic main_undervolt_lockout;
        logic core_rail;
        logic rail_3v3;
        logic rail_2v5;
        logic rail_5v;
        logic charge_pump_voltage;
        logic internal_reg_voltage;
    } prs_cmp_t;

    // regulator enables
    typedef struct packed {
        logic core_rail;
        logic rail_3v3;
        logic rail_2v5;
        logic linear_rail_a;
        logic linear_rail_b;
        logic rail_5v;
        logic motor_rail;
    } prs_en_t;

    // serial-port disable bits for optional rails
    typedef struct packed {
        logic linear_rail_a;
        logic linear_rail_b;
        logic rail_5v;
        logic motor_rail;
    } prs_opt_t;

    typedef struct packed {
        logic fan_reset_mask;
        logic regulator_reset_mask;
        logic motor_cfg_reset_mask;
        logic motor_outen_reset_mask;
    } prs_mask_t;
endpackage

// file: testbench/prs_analog_model.sv
`timescale 1ns/1ps
module prs_analog_model import prs_pkg::*; (
    input wire logic clock,
    input wire prs_en_t rail_en,
    input wire prs_cmp_t ok_mask,
    output prs_cmp_t cmp_in
);
    prs_en_t up_reg = '0;
    // a rail reads good one cycle after its enable, never while the bench pulls it low
    always @(posedge clock) begin
        up_reg <= rail_en;
    end
    assign cmp_in = ok_mask & {2'b11, up_reg.core_rail, up_reg.rail_3v3, up_reg.rail_2v5,
        up_reg.rail_5v, 2'b11};
endmodule // prs_analog_model

// file: testbench/prs_sequencer_chk.sv
`timescale 1ns/1ps
module prs_sequencer_chk import prs_pkg::*; #(
    parameter int SOFT_START_CNT = SOFT_START_CYCLES,
    parameter int RAILS_OK_CNT = RAILS_OK_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire prs_cmp_t cmp_in,
    input wire logic [TEMP_W-1:0] junction_temp,
    input wire logic ext_reset_n,
    input wire prs_mask_t reset_mask,
    input wire prs_en_t rail_en,
    input wire logic rails_ok_flag,
    input wire logic supply_good_flag,
    input wire logic overtemp_warn,
    input wire logic thermal_shutdown,
    input wire logic [FAN_N-1:0] fan_en,
    input wire logic [FAN_N*PWM_W-1:0] fan_pwm,
    input wire prs_opt_t opt_disable
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    int core_cnt;
    int prim_cnt;
    logic prim_up;
    logic fault;
    assign prim_up = cmp_in.core_rail && cmp_in.rail_3v3 && cmp_in.rail_2v5;
    assign fault = !(cmp_in.main_undervolt_shutdown && cmp_in.charge_pump_voltage
        && cmp_in.internal_reg_voltage);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            core_cnt <= 0;
            prim_cnt <= 0;
        end else begin
            core_cnt <= rail_en.core_rail ? core_cnt + 1 : 0;
            prim_cnt <= prim_up ? prim_cnt + 1 : 0;
        end
    end
    a_core_soft_start: assert property (
        $rose(rail_en.rail_3v3) |-> core_cnt >= SOFT_START_CNT - 1) else $error("early 3v3");
    a_rails_ok_delay: assert property (
        $rose(rails_ok_flag) |-> prim_cnt >= RAILS_OK_CNT) else $error("early rails ok");
    a_good_needs_ok: assert property (
        supply_good_flag |-> rails_ok_flag) else $error("supply good alone");
    a_primary_drop: assert property (
        !prim_up && rails_ok_flag |-> ##[1:3] !rails_ok_flag && !supply_good_flag)
        else $error("flags kept");
    a_fault_off: assert property (
        fault |-> ##[1:3] rail_en == '0) else $error("rails on in fault");
    a_hot_off: assert property (
        junction_temp >= TEMP_SHUT_C |-> ##[1:3] thermal_shutdown && rail_en == '0)
        else $error("no thermal stop");
    a_warn_level: assert property (
        (junction_temp >= TEMP_WARN_C) [*4] |-> overtemp_warn) else $error("no warning");
    a_linear_no_5v: assert property (
        !cmp_in.rail_5v [*4] |-> !rail_en.linear_rail_a && !rail_en.linear_rail_b)
        else $error("linear without 5v");
    a_fan_reset: assert property (
        (!ext_reset_n && !reset_mask.fan_reset_mask) [*4] |-> fan_en == '0 && fan_pwm == '0)
        else $error("fan kept");
    a_reg_reset: assert property (
        (!ext_reset_n && !reset_mask.regulator_reset_mask) [*4] |-> opt_disable[3:1] == '0)
        else $error("regulators kept");
endmodule // prs_sequencer_chk
bind prs_sequencer prs_sequencer_chk #(.SOFT_START_CNT(SOFT_START_CNT),
    .RAILS_OK_CNT(RAILS_OK_CNT)) chk_u (.clock(clock), .rstn(rstn), .cmp_in(cmp_in),
    .junction_temp(junction_temp), .ext_reset_n(ext_reset_n), .reset_mask(reset_mask),
    .rail_en(rail_en), .rails_ok_flag(rails_ok_flag), .supply_good_flag(supply_good_flag),
    .overtemp_warn(overtemp_warn), .thermal_shutdown(thermal_shutdown), .fan_en(fan_en),
    .fan_pwm(fan_pwm), .opt_disable(opt_disable));

// file: testbench/power_rail_sequencer_tb.sv
`timescale 1ns/1ps
module power_rail_sequencer_tb import prs_pkg::*;;
    localparam int SS = 20;
    localparam int RO = 50;
    logic clock = 1'b0, rstn = 1'b0, ext_n = 1'b1, wr = 1'b0, moe = 1'b0, moe_q, rok, sg, warn, tsd;
    logic [TEMP_W-1:0] temp = 8'h19;
    logic [2:0] fan = '0, fan_q;
    logic [23:0] pwm = '0, pwm_q;
    logic [15:0] mcfg = '0, mcfg_q;
    prs_mask_t mask = '0;
    prs_opt_t opt = '0, opt_q;
    prs_cmp_t ok = '1, cmp;
    prs_en_t en;
    int bad_count = 0, compares = 0, cyc = 0;
    prs_sequencer #(.SOFT_START_CNT(SS), .RAILS_OK_CNT(RO)) dut_u (.clock(clock), .rstn(rstn),
        .clk_en(1'b1), .cmp_in(cmp), .junction_temp(temp), .ext_reset_n(ext_n),
        .reset_mask(mask), .wr_en(wr), .wr_opt_disable(opt), .wr_fan_en(fan), .wr_fan_pwm(pwm),
        .wr_motor_cfg(mcfg), .wr_motor_outen(moe), .rail_en(en), .rails_ok_flag(rok),
        .supply_good_flag(sg), .overtemp_warn(warn), .thermal_shutdown(tsd), .fan_en(fan_q),
        .fan_pwm(pwm_q), .motor_cfg(mcfg_q), .motor_outen(moe_q), .opt_disable(opt_q));
    prs_analog_model model_u (.clock(clock), .rail_en(en), .ok_mask(ok), .cmp_in(cmp));
    always #2 clock = ~clock;
    task automatic stop_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            bad_count++;
            $display("MISMATCH %0t timeout", $time);
            stop_test();
        end
    end
    task automatic chk(input logic c, input string s);
        compares++;
        if (c !== 1'b1) begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wait_up(input int lo, input string s);
        int k;
        k = 0;
        while (rok !== 1'b1 && k < 400) begin
            @(posedge clock);
            #1;
            k++;
        end
        chk(k >= lo && k <= lo + 14, s);
        chk(sg === 1'b1 && en === '1, s);
        $display("test %s done", s);
    endtask
    // regulator mask guards linear and 5v disables only; motor disable is never reset
    function automatic prs_opt_t exp_opt(input prs_opt_t d, input prs_mask_t m);
        exp_opt = d;
        if (!m.regulator_reset_mask) exp_opt[3:1] = 3'h0;
    endfunction
    initial begin
        void'($urandom(32'hc4ed6070));
        tick(5);
        rstn <= 1'b1;
        tick(8);
        #1;
        chk(en.core_rail === 1'b1 && en.rail_3v3 === 1'b0, "core first");
        wait_up(SS + RO - 8, "power_up");
        tick(1);
        ok.main_undervolt_lockout <= 1'b0;
        tick(4);
        #1;
        chk(sg === 1'b0 && rok === 1'b1 && en === '1, "lockout");
        tick(1);
        ok.main_undervolt_lockout <= 1'b1;
        ok.rail_2v5 <= 1'b0;
        tick(4);
        #1;
        chk(rok === 1'b0 && sg === 1'b0 && en.rail_3v3 === 1'b1, "rail drop");
        tick(1);
        ok.rail_2v5 <= 1'b1;
        wait_up(RO, "redelay");
        for (int i = 0; i < 9; i++) begin
            tick(4);
            wr <= 1'b1;
            opt <= i == 8 ? 4'h0 : 4'($urandom);
            fan <= 3'($urandom);
            pwm <= 24'($urandom);
            mcfg <= 16'($urandom);
            moe <= 1'($urandom);
            mask <= i < 2 ? {4{i[0]}} : 4'($urandom);
            tick(1);
            wr <= 1'b0;
            if (i == 8) break;
            tick(8);
            #1;
            chk(fan_q === fan && pwm_q === pwm && mcfg_q === mcfg && moe_q === moe, "wr");
            chk(opt_q === opt && en.rail_5v === !opt.rail_5v, "opt");
            chk(en.motor_rail === !opt.motor_rail, "motor");
            chk(en.linear_rail_a === !(opt.linear_rail_a || opt.rail_5v), "lin");
            chk(en.linear_rail_b === !(opt.linear_rail_b || opt.rail_5v), "linb");
            tick(1);
            ext_n <= 1'b0;
            tick(5);
            #1;
            chk(fan_q === (mask.fan_reset_mask ? fan : 3'h0), "fan");
            chk(pwm_q === (mask.fan_reset_mask ? pwm : 24'h0), "pwm");
            chk(mcfg_q === (mask.motor_cfg_reset_mask ? mcfg : 16'h0), "cfg");
            chk(moe_q === (mask.motor_outen_reset_mask & moe), "outen");
            chk(opt_q === exp_opt(opt, mask), "reg");
            tick(1);
            ext_n <= 1'b1;
        end
        $display("test ext_reset done");
        temp <= 8'h8c;
        tick(8);
        #1;
        chk(warn === 1'b1 && en === '1, "warn");
        for (int i = 0; i < 4; i++) begin
            tick(1);
            if (i == 3) temp <= 8'haa;
            else ok[i == 0 ? 7 : i - 1] <= 1'b0;
            tick(4);
            #1;
            chk(en === '0 && rok === 1'b0 && sg === 1'b0, "fault");
            tick(1);
            temp <= 8'h9b;
            tick(4);
            #1;
            chk(i < 3 || (tsd === 1'b1 && en === '0), "hyst");
            tick(1);
            ok <= '1;
            temp <= 8'h28 + 8'($urandom_range(79));
            wait_up(SS + RO, "restart");
            chk(tsd === 1'b0, "tsd clear");
        end
        stop_test();
    end
endmodule // power_rail_sequencer_tb
